/* File: core/embp_top.sv */
// external memory bus pins: command fifo, bus sequencer, port muxing
// assumes AXI4-Lite master on clock; pins pass two-flop synchronisers
//
// How it works
// - combined mode: strobe every write
// - low-byte mode: low-byte or 8-bit writes
// - ready high keeps adding waitstates
// - ale pulses in multiplexed modes
// - strap low boots external, high internal
// - per-pin direction bits when not bus
// - input pins leave driver off
// - port a: mux addr/data, demux data
// - port b: address, stays after mux
// - read strobe on every read
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module embp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] n;
   } embp_fifo_s;
   embp_fifo_s q, d;
   logic [W-1:0] mem [D];
   logic push, pop;

   assign in_ready = q.n != (AW+1)'(D);
   assign out_valid = q.n != '0;
   assign out_data = mem[q.rp];

   always_comb
   begin
      d = q;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push)
         d.wp = (q.wp == AW'(D - 1)) ? '0 : AW'(q.wp + 1'b1);
      if (pop)
         d.rp = (q.rp == AW'(D - 1)) ? '0 : AW'(q.rp + 1'b1);
      if (push && !pop)
         d.n = (AW+1)'(q.n + 1'b1);
      else if (pop && !push)
         d.n = (AW+1)'(q.n - 1'b1);
   end

   // storage has no reset: out_data is only taken while the count is not zero
   always_ff @(posedge clock)
   begin
      if (push)
         mem[q.wp] <= in_data;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule

module embp_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite write
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // bus port a
   input wire logic [15:0] bus_port_a_in,
   output logic [15:0] bus_port_a_out,
   output logic [15:0] bus_port_a_oe,
   // bus port b
   input wire logic [15:0] bus_port_b_in,
   output logic [15:0] bus_port_b_out,
   output logic [15:0] bus_port_b_oe,
   // control pins
   output logic ale,
   output logic read_strobe_n,
   output logic write_strobe_low_byte_n,
   input wire logic ready_in,
   input wire logic external_access_strap,
   output logic boot_from_external
);
   typedef struct packed {
      logic awr;
      logic bv;
      logic [1:0] br;
      logic arr;
      logic rv;
      logic [1:0] rr;
      logic [31:0] rd;
      embp_pkg::embp_mode_e mode;
      logic lowb;
      logic rdyen;
      logic [15:0] dir_a;
      logic [15:0] dir_b;
      logic [15:0] out_a;
      logic [15:0] out_b;
      logic [15:0] addr;
      logic [1:0] be;
      logic [15:0] rdat;
      logic rdone;
      logic addrb;
      logic boot;
      logic [1:0] bcnt;
      embp_pkg::embp_st_e st;
      embp_pkg::embp_cmd_s cmd;
      logic [2:0] cnt;
      logic [15:0] a1;
      logic [15:0] a2;
      logic [15:0] b1;
      logic [15:0] b2;
      logic r1;
      logic r2;
      logic e1;
      logic e2;
      logic [15:0] pa_o;
      logic [15:0] pa_oe;
      logic [15:0] pb_o;
      logic [15:0] pb_oe;
      logic ale;
      logic rd_n;
      logic wr_n;
   } embp_state_s;

   embp_state_s q, d;
   logic push_v, push_r, f_v, f_r;
   embp_pkg::embp_cmd_s push_c, f_c;
   logic [15:0] bm, bus_o;
   logic bus_oe, hit;

   function automatic logic is_mux(embp_pkg::embp_mode_e m);
      return m == embp_pkg::M_MUX16 || m == embp_pkg::M_MUX8;
   endfunction

   function automatic logic is_dmx(embp_pkg::embp_mode_e m);
      return m == embp_pkg::M_DMX16 || m == embp_pkg::M_DMX8;
   endfunction

   function automatic logic [15:0] wmask(logic [15:0] old, logic [31:0] w, logic [3:0] s);
      return {s[1] ? w[15:8] : old[15:8], s[0] ? w[7:0] : old[7:0]};
   endfunction

   function automatic logic ok_addr(logic [31:0] a);
      return a[31:8] == 24'h000000 && a[1:0] == 2'h0 && a[7:0] <= embp_pkg::A_STAT;
   endfunction

   embp_fifo #(
      .W(embp_pkg::CMD_W),
      .D(embp_pkg::FIFO_D)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(push_v),
      .in_ready(push_r),
      .in_data(push_c),
      .out_valid(f_v),
      .out_ready(f_r),
      .out_data(f_c)
   );

   // sequencer takes a new command only when idle
   assign f_r = q.st == embp_pkg::S_IDLE;

   always_comb
   begin
      d = q;
      push_v = 1'b0;
      push_c = '0;
      // pins: only the second stage of each synchroniser is read
      d.a1 = bus_port_a_in;
      d.a2 = q.a1;
      d.b1 = bus_port_b_in;
      d.b2 = q.b1;
      d.r1 = ready_in;
      d.r2 = q.r1;
      d.e1 = external_access_strap;
      d.e2 = q.e1;
      // write channel: both halves are taken together
      d.awr = 1'b0;
      if (q.bv && bready)
         d.bv = 1'b0;
      hit = awaddr[7:0] == embp_pkg::A_WDATA || awaddr[7:0] == embp_pkg::A_RDREQ;
      // a full fifo stalls the bus write, never drops the command
      if (!q.awr && !q.bv && awvalid && wvalid && (push_r || !hit))
         d.awr = 1'b1;
      if (q.awr)
      begin
         d.bv = 1'b1;
         d.br = ok_addr(awaddr) ? embp_pkg::OKAY : embp_pkg::SLVERR;
         if (ok_addr(awaddr))
         begin
            case (awaddr[7:0])
               embp_pkg::A_CTRL:
               begin
                  if (wstrb[0])
                  begin
                     d.mode = embp_pkg::embp_mode_e'(wdata[embp_pkg::F_MODE +: 3]);
                     d.lowb = wdata[embp_pkg::F_LOWB];
                     d.rdyen = wdata[embp_pkg::F_RDYEN];
                  end
               end
               embp_pkg::A_DIR_A: d.dir_a = wmask(q.dir_a, wdata, wstrb);
               embp_pkg::A_DIR_B: d.dir_b = wmask(q.dir_b, wdata, wstrb);
               embp_pkg::A_OUT_A: d.out_a = wmask(q.out_a, wdata, wstrb);
               embp_pkg::A_OUT_B: d.out_b = wmask(q.out_b, wdata, wstrb);
               embp_pkg::A_ADDR:
               begin
                  d.addr = wmask(q.addr, wdata, wstrb);
                  if (wstrb[2])
                     d.be = wdata[embp_pkg::F_BE +: 2];
               end
               embp_pkg::A_WDATA:
               begin
                  push_v = 1'b1;
                  push_c = '{wr: 1'b1, be: q.be, addr: q.addr, data: wdata[15:0]};
               end
               embp_pkg::A_RDREQ:
               begin
                  push_v = 1'b1;
                  push_c = '{wr: 1'b0, be: q.be, addr: q.addr, data: 16'h0000};
               end
               default: ;
            endcase
         end
      end
      // read channel
      d.arr = 1'b0;
      if (q.rv && rready)
         d.rv = 1'b0;
      if (!q.arr && !q.rv && arvalid)
         d.arr = 1'b1;
      if (q.arr)
      begin
         d.rv = 1'b1;
         d.rd = 32'h00000000;
         d.rr = ok_addr(araddr) ? embp_pkg::OKAY : embp_pkg::SLVERR;
         if (ok_addr(araddr))
         begin
            case (araddr[7:0])
               embp_pkg::A_CTRL: d.rd[4:0] = {q.rdyen, q.lowb, q.mode};
               embp_pkg::A_DIR_A: d.rd[15:0] = q.dir_a;
               embp_pkg::A_DIR_B: d.rd[15:0] = q.dir_b;
               embp_pkg::A_OUT_A: d.rd[15:0] = q.out_a;
               embp_pkg::A_OUT_B: d.rd[15:0] = q.out_b;
               embp_pkg::A_PIN_A: d.rd[15:0] = q.a2;
               embp_pkg::A_PIN_B: d.rd[15:0] = q.b2;
               embp_pkg::A_ADDR: d.rd[17:0] = {q.be, q.addr};
               embp_pkg::A_RDATA:
               begin
                  d.rd[15:0] = q.rdat;
                  d.rdone = 1'b0;
               end
               embp_pkg::A_STAT:
               begin
                  d.rd[embp_pkg::F_BUSY] = q.st != embp_pkg::S_IDLE || f_v;
                  d.rd[embp_pkg::F_RDONE] = q.rdone;
                  d.rd[embp_pkg::F_BOOT] = q.boot;
                  d.rd[embp_pkg::F_ADDRB] = q.addrb;
               end
               default: ;
            endcase
         end
      end
      // bus sequencer
      case (q.st)
         embp_pkg::S_IDLE:
         begin
            if (f_v)
            begin
               d.cmd = f_c;
               d.st = embp_pkg::S_ALE;
            end
         end
         embp_pkg::S_ALE: d.st = embp_pkg::S_HOLD;
         embp_pkg::S_HOLD:
         begin
            d.st = embp_pkg::S_STB;
            d.cnt = embp_pkg::STB_MIN;
         end
         embp_pkg::S_STB:
         begin
            // minimum length lets the synchronised data settle
            if (q.cnt != 3'h0)
               d.cnt = 3'(q.cnt - 3'h1);
            else if (!(q.rdyen && q.r2))
            begin
               d.st = embp_pkg::S_IDLE;
               if (!q.cmd.wr)
               begin
                  d.rdat = (q.mode == embp_pkg::M_MUX8 || q.mode == embp_pkg::M_DMX8)
                     ? {8'h00, q.a2[7:0]} : q.a2;
                  d.rdone = 1'b1;
               end
            end
         end
         default: d.st = embp_pkg::S_IDLE;
      endcase
      // a demux mode claims port b until single-chip mode returns
      d.addrb = is_dmx(d.mode) || (q.addrb && is_mux(d.mode));
      // strap is caught over the cycles after release
      if (q.bcnt != embp_pkg::BOOT_CNT)
      begin
         d.bcnt = 2'(q.bcnt + 2'h1);
         d.boot = !q.e2;
      end
      // pin values follow the next state so they agree with it
      d.ale = d.st == embp_pkg::S_ALE && is_mux(d.mode);
      d.rd_n = !(d.st == embp_pkg::S_STB && !d.cmd.wr);
      d.wr_n = !(d.st == embp_pkg::S_STB && d.cmd.wr
         && (!d.lowb
         || d.mode == embp_pkg::M_MUX8 || d.mode == embp_pkg::M_DMX8 || d.cmd.be[0]));
      case (d.mode)
         embp_pkg::M_DMX16, embp_pkg::M_MUX16: bm = 16'hFFFF;
         embp_pkg::M_DMX8, embp_pkg::M_MUX8: bm = 16'h00FF;
         default: bm = 16'h0000;
      endcase
      // address on the shared lines through ale and its hold cycle
      if (is_mux(d.mode) && (d.st == embp_pkg::S_ALE || d.st == embp_pkg::S_HOLD))
      begin
         bus_o = d.cmd.addr;
         bus_oe = 1'b1;
      end
      else
      begin
         bus_o = d.cmd.data;
         bus_oe = d.st == embp_pkg::S_STB && d.cmd.wr;
      end
      d.pa_o = (bm & bus_o) | (~bm & d.out_a);
      d.pa_oe = (bm & {16{bus_oe}}) | (~bm & d.dir_a);
      d.pb_o = d.addrb ? d.cmd.addr : d.out_b;
      d.pb_oe = d.addrb ? 16'hFFFF : d.dir_b;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.mode <= embp_pkg::M_SINGLE;
         q.st <= embp_pkg::S_IDLE;
         q.dir_a <= embp_pkg::DIR_RST;
         q.dir_b <= embp_pkg::DIR_RST;
         q.out_a <= embp_pkg::OUT_RST;
         q.out_b <= embp_pkg::OUT_RST;
         q.be <= embp_pkg::BE_RST;
         q.rd_n <= 1'b1;
         q.wr_n <= 1'b1;
      end
      else
         q <= d;
   end

   assign awready = q.awr;
   assign wready = q.awr;
   assign bvalid = q.bv;
   assign bresp = q.br;
   assign arready = q.arr;
   assign rvalid = q.rv;
   assign rresp = q.rr;
   assign rdata = q.rd;
   assign bus_port_a_out = q.pa_o;
   assign bus_port_a_oe = q.pa_oe;
   assign bus_port_b_out = q.pb_o;
   assign bus_port_b_oe = q.pb_oe;
   assign ale = q.ale;
   assign read_strobe_n = q.rd_n;
   assign write_strobe_low_byte_n = q.wr_n;
   assign boot_from_external = q.boot;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_WR_COMBINED: assert property (q.st == embp_pkg::S_STB && q.cmd.wr && !q.lowb
      |-> !write_strobe_low_byte_n) else $error("write strobe missing in combined mode");
   AST_WR_LOWBYTE: assert property (q.st == embp_pkg::S_STB && q.cmd.wr && q.lowb
      && q.mode == embp_pkg::M_MUX16 && !q.cmd.be[0] |-> write_strobe_low_byte_n)
      else $error("write strobe on high-byte write");
   AST_READY_WAIT: assert property (q.st == embp_pkg::S_STB && q.cnt == 3'h0 && q.rdyen
      && q.r2 |=> q.st == embp_pkg::S_STB) else $error("access ended while ready high");
   AST_ALE_MUX: assert property (ale |-> is_mux(q.mode) && !$past(ale)
      ##1 !ale) else $error("ale outside a one-cycle mux address phase");
   AST_BOOT: assert property (q.bcnt == 2'h2 ##1 q.bcnt == embp_pkg::BOOT_CNT
      |-> boot_from_external == !$past(q.e2)) else $error("strap not captured");
   AST_ADDR_HOLD: assert property ($fell(ale) && q.mode == embp_pkg::M_MUX16
      |-> bus_port_a_oe == 16'hFFFF && bus_port_a_out == q.cmd.addr)
      else $error("address released as ale fell");
   AST_READ_OFF: assert property (!read_strobe_n && q.mode == embp_pkg::M_MUX8
      |-> bus_port_a_oe[7:0] == 8'h00 && bus_port_a_oe[15:8] == q.dir_a[15:8])
      else $error("port a driven during read");
   AST_PORTB_ADDR: assert property (q.addrb && $past(q.addrb) && is_mux(q.mode)
      |-> bus_port_b_oe == 16'hFFFF) else $error("port b address lost after switch");
   AST_GPIO_DIR: assert property (q.mode == embp_pkg::M_SINGLE && !q.addrb
      |-> bus_port_a_oe == q.dir_a && bus_port_b_oe == q.dir_b)
      else $error("gpio driver does not follow direction");
   AST_READ_STROBE: assert property ($fell(read_strobe_n)
      |-> !read_strobe_n [*4]) else $error("read strobe too short");
endmodule

/* File: core/embp_pkg.sv */
// constants and types for the external memory bus pin block
// assumes one 20 MHz clock and an AXI4-Lite register master
package embp_pkg;
   typedef enum logic [2:0] {M_SINGLE, M_DMX16, M_MUX16, M_MUX8, M_DMX8} embp_mode_e;
   typedef enum logic [1:0] {S_IDLE, S_ALE, S_HOLD, S_STB} embp_st_e;
   typedef struct packed {
      logic wr;
      logic [1:0] be;
      logic [15:0] addr;
      logic [15:0] data;
   } embp_cmd_s;
   localparam int CMD_W = $bits(embp_cmd_s);
   localparam int FIFO_D = 8;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_DIR_A = 8'h04;
   localparam logic [7:0] A_DIR_B = 8'h08;
   localparam logic [7:0] A_OUT_A = 8'h0C;
   localparam logic [7:0] A_OUT_B = 8'h10;
   localparam logic [7:0] A_PIN_A = 8'h14;
   localparam logic [7:0] A_PIN_B = 8'h18;
   localparam logic [7:0] A_ADDR = 8'h1C;
   localparam logic [7:0] A_WDATA = 8'h20;
   localparam logic [7:0] A_RDREQ = 8'h24;
   localparam logic [7:0] A_RDATA = 8'h28;
   localparam logic [7:0] A_STAT = 8'h2C;
   // field positions
   localparam int F_MODE = 0;
   localparam int F_LOWB = 3;
   localparam int F_RDYEN = 4;
   localparam int F_BE = 16;
   localparam int F_BUSY = 0;
   localparam int F_RDONE = 1;
   localparam int F_BOOT = 2;
   localparam int F_ADDRB = 3;
   // reset values
   localparam logic [15:0] DIR_RST = 16'h0000;
   localparam logic [15:0] OUT_RST = 16'h0000;
   localparam logic [1:0] BE_RST = 2'h3;
   // strobe phase length in cycles before ready is looked at
   localparam logic [2:0] STB_MIN = 3'h3;
   localparam logic [1:0] BOOT_CNT = 2'h3;
   localparam logic [1:0] OKAY = 2'h0;
   localparam logic [1:0] SLVERR = 2'h2;
endpackage

/* File: sim/embp_mem_model.sv */
// far-side memory model: 16 words, address from ale latch or port b
// assumes active-low strobes and bus pins resolved by the bench
`timescale 1ns/1ns
module embp_mem_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // pins seen from the far side
   input wire logic [15:0] pa_out,
   input wire logic [15:0] pb_out,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   // bench control
   input wire logic [7:0] wait_n,
   // model outputs
   output logic [15:0] pa_drv,
   output logic pa_en,
   output logic rdy,
   output logic [15:0] lat_a,
   output logic [15:0] wr_cnt,
   output logic [15:0] rd_cnt,
   output logic [15:0] last_wd,
   output logic [7:0] stb_len
);
   logic [15:0] mem [16];
   logic [15:0] cur, wbuf, wadr;
   logic [7:0] cnt;
   logic seen, rd_q, wr_q;
   // no ale seen means demultiplexed: address sits on port b
   assign cur = seen ? lat_a : pb_out;
   assign pa_en = !rd_n;
   assign pa_drv = mem[cur[3:0]];
   // slow device: ready high for wait_n strobe cycles
   assign rdy = !(rd_n && wr_n) && cnt < wait_n;
   always_ff @(posedge clock)
   begin
      rd_q <= rd_n;
      wr_q <= wr_n;
      if (!rst_n)
      begin
         for (int i = 0; i < 16; i++)
            mem[i] <= {12'h100, i[3:0]};
         {lat_a, wr_cnt, rd_cnt, last_wd} <= 64'h0;
         {cnt, stb_len, seen} <= 17'h0;
      end
      else
      begin
         if (ale)
         begin
            lat_a <= pa_out;
            seen <= 1'h1;
         end
         if (rd_q && !rd_n)
            rd_cnt <= rd_cnt + 16'h1;
         if (!wr_n)
         begin
            wbuf <= pa_out;
            wadr <= cur;
         end
         if (!(rd_n && wr_n))
            cnt <= cnt + 8'h1;
         else if (!(rd_q && wr_q))
         begin
            stb_len <= cnt;
            cnt <= 8'h0;
            seen <= 1'h0;
         end
         if (!wr_q && wr_n)
         begin
            mem[wadr[3:0]] <= wbuf;
            last_wd <= wbuf;
            wr_cnt <= wr_cnt + 16'h1;
         end
      end
   end
endmodule

/* File: sim/tb_top.sv */
// bench for the external bus pin block with a far-side memory model
// assumes AXI4-Lite register map and timing as handed over
`timescale 1ns/1ns
module tb_top;
   logic clock, rst_n, strap, awvalid, wvalid, arvalid, bready, rready;
   logic awready, wready, bvalid, arready, rvalid, m_en, rdy, ale, rd_n, wr_n, boot;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [15:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, ext_b;
   logic [15:0] last_a = 16'h0;
   logic [15:0] m_drv, lat_a, wr_cnt, rd_cnt, last_wd;
   logic [7:0] wait_n, stb_len;
   int n_errors, comparisons;
   int cyc = 0;
   // released port a lines show the inverse of their last level unless the model drives them; port b shows ext_b
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & (m_en ? m_drv : ~last_a));
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
   embp_top uut (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .bus_port_a_in(pa_in), .bus_port_a_out(pa_out),
      .bus_port_a_oe(pa_oe), .bus_port_b_in(pb_in), .bus_port_b_out(pb_out),
      .bus_port_b_oe(pb_oe), .ale(ale), .read_strobe_n(rd_n),
      .write_strobe_low_byte_n(wr_n), .ready_in(rdy), .external_access_strap(strap),
      .boot_from_external(boot));
   embp_mem_model u_mem (.clock(clock), .rst_n(rst_n), .pa_out(pa_out), .pb_out(pb_out),
      .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .wait_n(wait_n), .pa_drv(m_drv),
      .pa_en(m_en), .rdy(rdy), .lat_a(lat_a), .wr_cnt(wr_cnt), .rd_cnt(rd_cnt),
      .last_wd(last_wd), .stb_len(stb_len));
   initial
   begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      last_a <= pa_in;
      cyc <= cyc + 1;
      // whole run needs about a thousand cycles
      if (cyc == 40000)
      begin
         n_errors++;
         give_verdict;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bready and rready stay high, so each answer is taken at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!done)
      begin
         @(posedge clock);
         // each channel lets go only when its own ready is seen
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            done = 1'h1;
            chk("bresp", embp_pkg::OKAY, bresp);
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'h0;
      araddr <= {24'h0, a};
      arvalid <= 1'h1;
      while (!done)
      begin
         @(posedge clock);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            done = 1'h1;
            v = rdata;
            r = rresp;
         end
      end
   endtask
   task automatic idle;
      repeat (4) @(posedge clock);
      do rd(embp_pkg::A_STAT); while (v[embp_pkg::F_BUSY]);
   endtask
   task automatic rst;
      rst_n <= 1'h0;
      repeat (3) @(posedge clock);
      rst_n <= 1'h1;
      repeat (5) @(posedge clock);
   endtask
   task automatic t_reset;
      strap <= 1'h0;
      rst;
      chk("boot ext", 32'h1, boot);
      chk("oe a", 32'h0, pa_oe);
      chk("strobes", 32'h3, {rd_n, wr_n});
      strap <= 1'h1;
      rst;
      chk("boot int", 32'h0, boot);
      $display("test reset done");
   endtask
   task automatic t_gpio;
      ext_b <= 16'h1234;
      wr(embp_pkg::A_DIR_A, 32'h00FF);
      wr(embp_pkg::A_OUT_A, 32'h00A5);
      wr(embp_pkg::A_DIR_B, 32'hFF00);
      repeat (2) @(posedge clock);
      chk("oe a", 32'h00FF, pa_oe);
      chk("out a", 32'hA5, pa_out[7:0]);
      rd(embp_pkg::A_PIN_B);
      chk("pin b", 32'h0034, v);
      rd(8'h40);
      chk("unmapped", embp_pkg::SLVERR, r);
      $display("test gpio done");
   endtask
   task automatic t_mux;
      logic [15:0] n;
      wr(embp_pkg::A_CTRL, 32'h2);
      wr(embp_pkg::A_ADDR, 32'h30012);
      n = wr_cnt;
      wr(embp_pkg::A_WDATA, 32'hBEEF);
      idle;
      chk("latched addr", 32'h0012, lat_a);
      chk("writes", n + 16'h1, wr_cnt);
      chk("wdata", 32'hBEEF, last_wd);
      n = rd_cnt;
      wr(embp_pkg::A_RDREQ, 32'h0);
      do rd(embp_pkg::A_STAT); while (!v[embp_pkg::F_RDONE]);
      rd(embp_pkg::A_RDATA);
      chk("rdata", 32'hBEEF, v);
      chk("reads", n + 16'h1, rd_cnt);
      $display("test mux done");
   endtask
   task automatic t_lowb;
      logic [7:0] cfg [5] = '{8'h02, 8'h0A, 8'h0A, 8'h0A, 8'h0B};
      logic [1:0] be [5] = '{2'h2, 2'h2, 2'h1, 2'h3, 2'h2};
      logic [15:0] inc [5] = '{16'h1, 16'h0, 16'h1, 16'h1, 16'h1};
      logic [15:0] n;
      for (int i = 0; i < 5; i++)
      begin
         wr(embp_pkg::A_CTRL, {24'h0, cfg[i]});
         wr(embp_pkg::A_ADDR, {14'h0, be[i], 16'h0013});
         n = wr_cnt;
         wr(embp_pkg::A_WDATA, 32'h5A5A);
         idle;
         chk("strobe count", n + inc[i], wr_cnt);
      end
      $display("test low byte done");
   endtask
   task automatic t_demux;
      wr(embp_pkg::A_CTRL, 32'h1);
      wr(embp_pkg::A_ADDR, 32'h30345);
      wr(embp_pkg::A_WDATA, 32'h1111);
      idle;
      chk("b oe", 32'hFFFF, pb_oe);
      chk("b addr", 32'h0345, pb_out);
      chk("demux data", 32'h1111, last_wd);
      wr(embp_pkg::A_CTRL, 32'h2);
      repeat (2) @(posedge clock);
      chk("b oe mux", 32'hFFFF, pb_oe);
      wr(embp_pkg::A_DIR_A, 32'hFF00);
      wr(embp_pkg::A_CTRL, 32'h3);
      repeat (2) @(posedge clock);
      chk("a high oe", 32'hFF, pa_oe[15:8]);
      // 8-bit multiplexed read: only the low lanes carry data
      wr(embp_pkg::A_RDREQ, 32'h0);
      do rd(embp_pkg::A_STAT); while (!v[embp_pkg::F_RDONE]);
      rd(embp_pkg::A_RDATA);
      chk("mux8 rdata", 32'h0011, v);
      // 8-bit demultiplexed write: address on port b, data low lanes
      wr(embp_pkg::A_CTRL, 32'h4);
      wr(embp_pkg::A_WDATA, 32'h22CC);
      idle;
      chk("demux8 data", 32'h00CC, last_wd);
      chk("b addr 8", 32'h0345, pb_out);
      $display("test demux done");
   endtask
   task automatic t_fifo;
      logic [15:0] n;
      int t, mx;
      mx = 0;
      wr(embp_pkg::A_CTRL, 32'h12);
      wait_n <= 8'h28;
      n = wr_cnt;
      // slow far side: one in flight, eight queued, the tenth must wait
      repeat (10)
      begin
         t = cyc;
         wr(embp_pkg::A_WDATA, 32'h7777);
         if (cyc - t > mx)
            mx = cyc - t;
      end
      chk("write held while full", 32'h1, mx > 20);
      idle;
      chk("drained", n + 16'hA, wr_cnt);
      chk("waitstates", 32'h1, stb_len >= 8'h28);
      wait_n <= 8'h0;
      $display("test fifo done");
   endtask
   initial
   begin
      {rst_n, strap, awvalid, wvalid, arvalid} = 5'h0;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      {bready, rready} = 2'h3;
      ext_b = 16'h0;
      wait_n = 8'h0;
      {n_errors, comparisons} = '0;
      @(posedge clock);
      t_reset;
      t_gpio;
      t_mux;
      t_lowb;
      t_demux;
      t_fifo;
      give_verdict;
   end
endmodule
